/* File: rtl/nfr_ahb_regs.v */
`timescale 1ns/1ps
`include "nfr_framing_regs.vh"
module nfr_ahb_regs (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire [7:0]  status,
	output reg  [7:0]  rate_q,
	output reg  [7:0]  typea_q,
	output reg  [7:0]  typeb_q,
	output reg  [7:0]  mode_q
);
	reg        wr_q;
	reg  [7:0] widx_q;
	wire       take;
	wire [7:0] ridx;
	reg  [7:0] rd_d;
	reg  [7:0] fwd;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign take      = hsel & hready & htrans[1];
	assign ridx      = haddr[9:2];

	// forward a write still in its data phase to a read of the same word
	always @* begin
		fwd = hwdata[7:0];
		case (ridx)
		`NFR_IDX_RATE:   rd_d = (wr_q && widx_q == ridx) ? (fwd & `NFR_MASK_RATE) : rate_q;
		`NFR_IDX_TYPEA:  rd_d = (wr_q && widx_q == ridx) ? (fwd & `NFR_MASK_TYPEA) : typea_q;
		`NFR_IDX_TYPEB:  rd_d = (wr_q && widx_q == ridx) ? (fwd & `NFR_MASK_TYPEB) : typeb_q;
		`NFR_IDX_MODE:   rd_d = (wr_q && widx_q == ridx) ? (fwd & `NFR_MASK_MODE) : mode_q;
		`NFR_IDX_STATUS: rd_d = status;
		default:         rd_d = 8'h00;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q    <= 1'b0;
			widx_q  <= 8'h00;
			hrdata  <= 32'h00000000;
			rate_q  <= `NFR_RST_RATE;
			typea_q <= `NFR_RST_TYPEA;
			typeb_q <= `NFR_RST_TYPEB;
			mode_q  <= `NFR_RST_MODE;
		end else begin
			wr_q   <= take & hwrite & (haddr[31:10] == 22'h000000);
			widx_q <= ridx;
			if (take && !hwrite)
				hrdata <= (haddr[31:10] == 22'h000000) ? {24'h000000, rd_d} : 32'h00000000;
			if (wr_q) begin
				case (widx_q)
				`NFR_IDX_RATE:  rate_q  <= hwdata[7:0] & `NFR_MASK_RATE;
				`NFR_IDX_TYPEA: typea_q <= hwdata[7:0] & `NFR_MASK_TYPEA;
				`NFR_IDX_TYPEB: typeb_q <= hwdata[7:0] & `NFR_MASK_TYPEB;
				`NFR_IDX_MODE:  mode_q  <= hwdata[7:0] & `NFR_MASK_MODE;
				default:        mode_q  <= mode_q;
				endcase
			end
		end
	end
endmodule

/* File: rtl/nfr_framing_rate.v */
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "nfr_framing_regs.vh"
module nfr_framing_rate (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output wire [31:0] hrdata,
	output reg         tx_enable,
	output reg         rx_enable,
	output reg  [7:0]  tx_bit_period,
	output reg  [7:0]  rx_bit_period,
	output reg  [7:0]  pulse_width,
	output reg         tx_parity_gen,
	output reg         rx_raw_parity,
	output reg         rx_check_en,
	output reg         anticoll_rx,
	output reg         rate_detect,
	output reg         detect_type_a,
	output reg         detect_second,
	output reg  [2:0]  egt_etu,
	output reg  [4:0]  sof_low_hetu,
	output reg  [4:0]  sof_high_hetu,
	output reg  [4:0]  eof_low_hetu,
	input  wire        tx_start,
	input  wire [7:0]  tx_len,
	input  wire        tx_in_valid,
	input  wire [7:0]  tx_in_data,
	output wire        tx_in_ready,
	output reg         tx_out_valid,
	output reg  [7:0]  tx_out_data,
	input  wire        tx_out_ready,
	output wire        tx_busy,
	input  wire        rx_sof,
	input  wire        rx_in_valid,
	input  wire [7:0]  rx_in_data,
	output reg         rx_out_valid,
	output reg  [7:0]  rx_out_data
);
	localparam ST_IDLE = 2'b00;
	localparam ST_START = 2'b01;
	localparam ST_LEN  = 2'b10;
	localparam ST_DATA = 2'b11;

	wire [7:0] rate_q;
	wire [7:0] typea_q;
	wire [7:0] typeb_q;
	wire [7:0] mode_q;
	wire [7:0] status;
	wire [1:0] tx_code;
	wire [1:0] rx_code;
	wire [3:0] plen;
	wire [3:0] operation_mode_code;
	wire [2:0] stx;
	wire       target;
	wire       reader;
	wire       stream_pw;
	wire       out_free;

	reg        mode_ok;
	reg        rate_ok;
	reg        pw_ok;
	reg  [7:0] pw_d;
	reg  [7:0] base;
	reg  [3:0] mag;
	reg  [7:0] tx_per_d;
	reg  [7:0] rx_per_d;

	reg  [1:0] st_q;
	reg  [1:0] st_d;
	reg  [7:0] cnt_q;
	reg  [7:0] len_q;
	reg        rx_first_q;

	nfr_ahb_regs u_regs (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.status    (status),
		.rate_q    (rate_q),
		.typea_q   (typea_q),
		.typeb_q   (typeb_q),
		.mode_q    (mode_q)
	);

	assign tx_code = rate_q[`NFR_TXR_HI:`NFR_TXR_LO];
	assign rx_code = rate_q[`NFR_RXR_HI:`NFR_RXR_LO];
	assign plen    = typea_q[`NFR_A_PLEN_HI:`NFR_A_PLEN_LO];
	assign operation_mode_code = mode_q[`NFR_M_OPMODE_HI:`NFR_M_OPMODE_LO];
	assign stx     = mode_q[`NFR_M_STX_HI:`NFR_M_STX_LO];
	assign target  = mode_q[`NFR_M_TARG];
	assign reader  = ~target;

	// stream pulse table applies only with zero stream period and mode 14
	assign stream_pw = reader & (operation_mode_code == `NFR_OPMODE_STREAM)
	                   & (stx == `NFR_STX_ZERO);

	assign status = {1'b0, rate_detect, rx_raw_parity, tx_parity_gen,
	                 pw_ok, rx_enable, tx_enable, tx_busy};

	// bit period in carrier cycles: 128 >> code
	always @* begin
		tx_per_d = `NFR_PERIOD_MAX >> tx_code;
		rx_per_d = `NFR_PERIOD_MAX >> rx_code;
	end

	// supported operation modes, initiator and target
	always @* begin
		if (target) begin
			case (operation_mode_code)
			4'h1:    mode_ok = 1'b1;
			4'h4:    mode_ok = 1'b1;
			4'h6:    mode_ok = 1'b1;
			default: mode_ok = operation_mode_code[3];
			endcase
		end else begin
			case (operation_mode_code)
			4'h0:    mode_ok = 1'b1;
			4'h1:    mode_ok = 1'b1;
			4'h2:    mode_ok = 1'b1;
			4'h3:    mode_ok = 1'b1;
			4'h4:    mode_ok = 1'b1;
			4'hE:    mode_ok = 1'b1;
			4'hF:    mode_ok = 1'b1;
			default: mode_ok = 1'b0;
			endcase
		end
		// two-bit fields leave no unused coding; reserved bits never reach here
		rate_ok = mode_ok;
	end

	// pulse width: base for rate plus signed step of the code
	always @* begin
		mag  = plen[3] ? (~plen + 4'h1) : plen;
		pw_d = 8'h00;
		pw_ok = 1'b0;
		case (tx_code)
		2'h0:    base = `NFR_PW_128;
		2'h1:    base = `NFR_PW_64;
		2'h2:    base = `NFR_PW_32;
		default: base = `NFR_PW_16;
		endcase
		if (stream_pw) begin
			pw_ok = (plen == 4'h0) | (plen[3] & (mag <= 4'h6));
			pw_d  = `NFR_PW_STREAM - {1'b0, mag, 3'b000};
		end else begin
			pw_d = plen[3] ? (base - {4'h0, mag}) : (base + {4'h0, plen});
			case (tx_code)
			2'h0:    pw_ok = 1'b1;
			2'h1:    pw_ok = plen[3] ? (mag <= 4'h6) : (plen <= 4'h6);
			2'h2:    pw_ok = plen[3] ? (mag <= 4'h4) : (plen <= 4'h4);
			default: pw_ok = plen[3] ? (mag <= 4'h3) : (plen <= 4'h3);
			endcase
		end
	end

	// decoded configuration, registered
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_enable     <= 1'b0;
			rx_enable     <= 1'b0;
			tx_bit_period <= 8'h00;
			rx_bit_period <= 8'h00;
			pulse_width   <= 8'h00;
			tx_parity_gen <= 1'b1;
			rx_raw_parity <= 1'b0;
			rx_check_en   <= 1'b1;
			anticoll_rx   <= 1'b0;
			rate_detect   <= 1'b0;
			detect_type_a <= 1'b0;
			detect_second <= 1'b0;
			egt_etu       <= 3'h0;
			sof_low_hetu  <= `NFR_HETU_10;
			sof_high_hetu <= `NFR_HETU_2;
			eof_low_hetu  <= `NFR_HETU_10;
		end else begin
			tx_enable     <= rate_ok & pw_ok;
			rx_enable     <= rate_ok;
			tx_bit_period <= tx_per_d;
			rx_bit_period <= rx_per_d;
			pulse_width   <= pw_ok ? pw_d : 8'h00;
			// parity options exist only in reader operation
			tx_parity_gen <= ~(typea_q[`NFR_A_NOTXPAR] & reader);
			rx_raw_parity <= typea_q[`NFR_A_NORXPAR] & reader
			                 & (rx_code == `NFR_RATE_106);
			rx_check_en   <= ~(typea_q[`NFR_A_NORXPAR] & reader
			                 & (rx_code == `NFR_RATE_106));
			anticoll_rx   <= typea_q[`NFR_A_ANTCL] & reader;
			rate_detect   <= target & operation_mode_code[3];
			detect_type_a <= target & operation_mode_code[3] & operation_mode_code[0];
			detect_second <= target & operation_mode_code[3] & operation_mode_code[2];
			egt_etu       <= typeb_q[`NFR_B_EGT_HI:`NFR_B_EGT_LO];
			if (typeb_q[`NFR_B_HALF]) begin
				sof_low_hetu  <= `NFR_HETU_MID_LO;
				sof_high_hetu <= `NFR_HETU_MID_HI;
				eof_low_hetu  <= `NFR_HETU_MID_LO;
			end else begin
				sof_low_hetu  <= typeb_q[`NFR_B_SOF0] ? `NFR_HETU_11 : `NFR_HETU_10;
				sof_high_hetu <= typeb_q[`NFR_B_SOF1] ? `NFR_HETU_3 : `NFR_HETU_2;
				eof_low_hetu  <= typeb_q[`NFR_B_EOF] ? `NFR_HETU_11 : `NFR_HETU_10;
			end
		end
	end

	// transmit framer: optional start byte and length ahead of the data
	assign out_free    = ~tx_out_valid | tx_out_ready;
	assign tx_in_ready = (st_q == ST_DATA) & out_free & (cnt_q != 8'h00);
	assign tx_busy     = (st_q != ST_IDLE) | tx_out_valid;

	always @* begin
		st_d = st_q;
		case (st_q)
		ST_IDLE: begin
			if (tx_start && tx_enable)
				st_d = typea_q[`NFR_A_TFRAME] ? ST_START : ST_DATA;
		end
		ST_START: begin
			if (out_free)
				st_d = ST_LEN;
		end
		ST_LEN: begin
			if (out_free)
				st_d = (len_q == 8'h00) ? ST_IDLE : ST_DATA;
		end
		ST_DATA: begin
			if (cnt_q == 8'h00)
				st_d = ST_IDLE;
			else if (tx_in_valid && out_free && cnt_q == 8'h01)
				st_d = ST_IDLE;
		end
		default: st_d = ST_IDLE;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q         <= ST_IDLE;
			cnt_q        <= 8'h00;
			len_q        <= 8'h00;
			tx_out_valid <= 1'b0;
			tx_out_data  <= 8'h00;
		end else begin
			st_q <= st_d;
			if (tx_out_valid && tx_out_ready)
				tx_out_valid <= 1'b0;
			case (st_q)
			ST_IDLE: begin
				if (tx_start && tx_enable) begin
					len_q <= tx_len;
					cnt_q <= tx_len;
				end
			end
			ST_START: begin
				if (out_free) begin
					tx_out_valid <= 1'b1;
					tx_out_data  <= `NFR_START_BYTE;
				end
			end
			ST_LEN: begin
				if (out_free) begin
					tx_out_valid <= 1'b1;
					tx_out_data  <= len_q;
				end
			end
			ST_DATA: begin
				if (tx_in_valid && tx_in_ready) begin
					tx_out_valid <= 1'b1;
					tx_out_data  <= tx_in_data;
					cnt_q        <= cnt_q - 8'h01;
				end
			end
			default: cnt_q <= 8'h00;
			endcase
		end
	end

	// receive: drop a leading start byte when transport framing is on
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_first_q   <= 1'b0;
			rx_out_valid <= 1'b0;
			rx_out_data  <= 8'h00;
		end else begin
			rx_out_valid <= 1'b0;
			if (rx_sof)
				rx_first_q <= 1'b1;
			if (rx_in_valid && rx_enable) begin
				rx_first_q <= 1'b0;
				if (!(rx_first_q && typea_q[`NFR_A_TFRAME]
				      && rx_in_data == `NFR_START_BYTE)) begin
					rx_out_valid <= 1'b1;
					rx_out_data  <= rx_in_data;
				end
			end
		end
	end
endmodule

/* File: rtl/nfr_framing_regs.vh */
// How it works
// - tx rate from bits 5:4, fc/128..fc/16
// - rx rate from bits 1:0, same coding
// - unsupported mode coding disables tx and rx; unsupported pulse code disables tx only
// - bit 7 set: transmit without parity bits
// - bit 6: raw rx with parity, 106k only
// - parity options only in reader operation
// - bit 5: add f0 and length, strip f0
// - pulse width fc/128 and fc/64 tables
// - pulse width fc/32 and fc/16 tables
// - stream mode pulse 128 down to 80
// - type b extra guard 0..7 etu
// - sof low 10 or 11 etu
// - sof high 2 or 3 etu
// - eof low 10 or 11 etu
// - mid bit forces mid-spec sof/eof
// - target msb selects rate detection mode
`ifndef NFR_FRAMING_REGS_VH
`define NFR_FRAMING_REGS_VH
`define NFR_IDX_RATE      8'h04
`define NFR_IDX_TYPEA     8'h05
`define NFR_IDX_TYPEB     8'h06
`define NFR_IDX_MODE      8'h10
`define NFR_IDX_STATUS    8'h11
`define NFR_MASK_RATE     8'h33
`define NFR_MASK_TYPEA    8'hFF
`define NFR_MASK_TYPEB    8'hFE
`define NFR_MASK_MODE     8'hFF
`define NFR_RST_RATE      8'h00
`define NFR_RST_TYPEA     8'h00
`define NFR_RST_TYPEB     8'h00
`define NFR_RST_MODE      8'h08
`define NFR_TXR_HI        5
`define NFR_TXR_LO        4
`define NFR_RXR_HI        1
`define NFR_RXR_LO        0
`define NFR_A_NOTXPAR     7
`define NFR_A_NORXPAR     6
`define NFR_A_TFRAME      5
`define NFR_A_PLEN_HI     4
`define NFR_A_PLEN_LO     1
`define NFR_A_ANTCL       0
`define NFR_B_EGT_HI      7
`define NFR_B_EGT_LO      5
`define NFR_B_SOF0        4
`define NFR_B_SOF1        3
`define NFR_B_EOF         2
`define NFR_B_HALF        1
`define NFR_M_TARG        7
`define NFR_M_OPMODE_HI   6
`define NFR_M_OPMODE_LO   3
`define NFR_M_STX_HI      2
`define NFR_M_STX_LO      0
`define NFR_RATE_106      2'h0
`define NFR_PERIOD_MAX    8'h80
`define NFR_START_BYTE    8'hF0
`define NFR_PW_128        8'h23
`define NFR_PW_64         8'h12
`define NFR_PW_32         8'h09
`define NFR_PW_16         8'h05
`define NFR_PW_STREAM     8'h80
`define NFR_OPMODE_STREAM 4'hE
`define NFR_STX_ZERO      3'h0
`define NFR_HETU_10       5'h14
`define NFR_HETU_11       5'h16
`define NFR_HETU_MID_LO   5'h15
`define NFR_HETU_2        5'h04
`define NFR_HETU_3        5'h06
`define NFR_HETU_MID_HI   5'h05
`endif

/* File: sim/nfc_framing_rate_config_tb.sv */
`timescale 1ns/1ps
`include "nfr_framing_regs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module nfc_framing_rate_config_tb;
	logic        hclk = 0, hresetn = 0, hwrite = 0, tx_start = 0, tx_in_valid = 0;
	logic [31:0] haddr = 0, hwdata = 0, q;
	logic [1:0]  htrans = 0;
	logic [7:0]  tx_len = 0, tx_in_data = 0, rx_last;
	int          num_errors = 0, samples_checked = 0, rx_n = 0, i, k;
	wire         hreadyout, hresp, tx_enable, rx_enable, tx_parity_gen, rx_raw_parity;
	wire         rx_check_en, anticoll_rx, rate_detect, detect_type_a, detect_second;
	wire         tx_in_ready, tx_out_valid, tx_out_ready, tx_busy, rx_sof, rx_in_valid;
	wire         rx_out_valid;
	wire [31:0]  hrdata;
	wire [7:0]   tx_bit_period, rx_bit_period, pulse_width, tx_out_data, rx_in_data;
	wire [7:0]   rx_out_data;
	wire [2:0]   egt_etu;
	wire [4:0]   sof_low_hetu, sof_high_hetu, eof_low_hetu;
	logic [7:0]  rc[7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h00, 8'h30, 8'h10};
	logic [7:0]  pc[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0E, 8'h10, 8'h14};
	logic [7:0]  ex[7] = '{8'h23, 8'h12, 8'h09, 8'h05, 8'h2A, 8'h00, 8'h0C};
	always #2.5 hclk = ~hclk;
	nfr_framing_rate dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_enable(tx_enable),
		.rx_enable(rx_enable), .tx_bit_period(tx_bit_period), .rx_bit_period(rx_bit_period),
		.pulse_width(pulse_width), .tx_parity_gen(tx_parity_gen), .rx_raw_parity(rx_raw_parity),
		.rx_check_en(rx_check_en), .anticoll_rx(anticoll_rx), .rate_detect(rate_detect),
		.detect_type_a(detect_type_a), .detect_second(detect_second), .egt_etu(egt_etu),
		.sof_low_hetu(sof_low_hetu), .sof_high_hetu(sof_high_hetu), .eof_low_hetu(eof_low_hetu),
		.tx_start(tx_start), .tx_len(tx_len), .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
		.tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
		.tx_out_ready(tx_out_ready), .tx_busy(tx_busy), .rx_sof(rx_sof), .rx_in_valid(rx_in_valid),
		.rx_in_data(rx_in_data), .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data));
	nfr_card_model card (.hclk(hclk), .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
		.tx_out_ready(tx_out_ready), .rx_sof(rx_sof), .rx_in_valid(rx_in_valid),
		.rx_in_data(rx_in_data));
	// host side byte source, counts from a0
	always @(posedge hclk) begin
		if (tx_in_valid && tx_in_ready === 1'b1) begin
			tx_in_data <= tx_in_data + 8'h01;
			if (tx_in_data == 8'hA0 + tx_len - 8'h01) tx_in_valid <= 1'b0;
		end
		if (rx_out_valid === 1'b1) begin
			rx_n <= rx_n + 1;
			rx_last <= rx_out_data;
		end
	end
	task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		haddr <= {22'h0, a, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task put(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
		repeat (2) @(posedge hclk);
		#1;
	endtask
	task t_reset;
		`CHK("rate", {24'h0, `NFR_RST_RATE}, q)
		bus(`NFR_IDX_TYPEB, 1'b0, 8'h00);
		`CHK("typeb", {24'h0, `NFR_RST_TYPEB}, q)
		#1;
		`CHK("txp", 8'h80, tx_bit_period)
		`CHK("pw", 8'h23, pulse_width)
		`CHK("sofl", 5'h14, sof_low_hetu)
		`CHK("sofh", 5'h04, sof_high_hetu)
		`CHK("eof", 5'h14, eof_low_hetu)
		`CHK("par", 1'b1, tx_parity_gen)
		put(8'h07, 8'hFF);
		bus(8'h07, 1'b0, 8'h00);
		`CHK("unmapped", 32'h0, q)
		$display("done reset");
	endtask
	task t_rates;
		for (i = 0; i < 4; i++) begin
			put(`NFR_IDX_RATE, 8'hCC | 8'(i << 4) | 8'(3 - i));
			`CHK("txp", 8'h80 >> i, tx_bit_period)
			`CHK("rxp", 8'h80 >> (3 - i), rx_bit_period)
			bus(`NFR_IDX_RATE, 1'b0, 8'h00);
			`CHK("rrd", 32'(i << 4 | (3 - i)), q)
		end
		$display("done rates");
	endtask
	task t_pulse;
		for (i = 0; i < 7; i++) begin
			put(`NFR_IDX_RATE, rc[i]);
			put(`NFR_IDX_TYPEA, pc[i]);
			`CHK("pw", ex[i], pulse_width)
			`CHK("txen", ex[i] != 8'h00, tx_enable)
		end
		put(`NFR_IDX_RATE, 8'h00);
		put(`NFR_IDX_MODE, 8'h70);
		put(`NFR_IDX_TYPEA, 8'h00);
		`CHK("pws0", 8'h80, pulse_width)
		put(`NFR_IDX_TYPEA, 8'h14);
		`CHK("pws10", 8'h50, pulse_width)
		put(`NFR_IDX_MODE, 8'h08);
		$display("done pulse");
	endtask
	task t_parity;
		put(`NFR_IDX_TYPEA, 8'h80);
		`CHK("par", 1'b0, tx_parity_gen)
		put(`NFR_IDX_TYPEA, 8'h41);
		`CHK("raw", 1'b1, rx_raw_parity)
		`CHK("chk", 1'b0, rx_check_en)
		`CHK("acl", 1'b1, anticoll_rx)
		put(`NFR_IDX_RATE, 8'h01);
		`CHK("raw64", 1'b0, rx_raw_parity)
		put(`NFR_IDX_RATE, 8'h00);
		put(`NFR_IDX_MODE, 8'h88);
		put(`NFR_IDX_TYPEA, 8'hC0);
		`CHK("tpar", 1'b1, tx_parity_gen)
		`CHK("traw", 1'b0, rx_raw_parity)
		`CHK("tacl", 1'b0, anticoll_rx)
		put(`NFR_IDX_MODE, 8'h08);
		put(`NFR_IDX_TYPEA, 8'h00);
		$display("done parity");
	endtask
	task t_typeb;
		for (i = 0; i < 8; i++) begin
			put(`NFR_IDX_TYPEB, 8'(i << 5));
			`CHK("egt", 3'(i), egt_etu)
		end
		put(`NFR_IDX_TYPEB, 8'h10);
		`CHK("sofl", 5'h16, sof_low_hetu)
		put(`NFR_IDX_TYPEB, 8'h08);
		`CHK("sofh", 5'h06, sof_high_hetu)
		put(`NFR_IDX_TYPEB, 8'h04);
		`CHK("eof", 5'h16, eof_low_hetu)
		put(`NFR_IDX_TYPEB, 8'hFF);
		`CHK("mid", 15'h54B5, {sof_low_hetu, sof_high_hetu, eof_low_hetu})
		bus(`NFR_IDX_TYPEB, 1'b0, 8'h00);
		`CHK("brd", 32'hFE, q)
		$display("done typeb");
	endtask
	task t_mode;
		put(`NFR_IDX_MODE, 8'h28);
		`CHK("off", 2'b00, {tx_enable, rx_enable})
		put(`NFR_IDX_MODE, 8'hC8);
		`CHK("det", 3'b110, {rate_detect, detect_type_a, detect_second})
		put(`NFR_IDX_MODE, 8'hE0);
		`CHK("det2", 3'b101, {rate_detect, detect_type_a, detect_second})
		put(`NFR_IDX_MODE, 8'h08);
		`CHK("on", 2'b11, {tx_enable, rx_enable})
		$display("done mode");
	endtask
	task t_frame(input logic [7:0] ta, input logic sl, input logic [31:0] e, input int n);
		put(`NFR_IDX_TYPEA, ta);
		card.slow = sl;
		card.got.delete();
		rx_n = 0;
		tx_len <= 8'h02;
		tx_start <= 1'b1;
		tx_in_valid <= 1'b1;
		tx_in_data <= 8'hA0;
		@(posedge hclk);
		tx_start <= 1'b0;
		k = 0;
		do begin @(posedge hclk); #1; k++; end while (tx_busy === 1'b1 && k < 200);
		`CHK("txn", n, card.got.size())
		for (i = 0; i < n; i++) `CHK("txb", e[31 - 8 * i -: 8], card.got[i])
		card.send(8'hF0, 8'h5C);
		repeat (3) @(posedge hclk);
		#1;
		`CHK("rxn", (n == 4) ? 1 : 2, rx_n)
		`CHK("rxd", 8'h5C, rx_last)
		$display("done frame");
	endtask
	task close_out;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		$display("BAD watchdog exp done got hang");
		close_out;
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(`NFR_IDX_RATE, 1'b0, 8'h00);
		t_reset;
		t_rates;
		t_pulse;
		t_parity;
		t_typeb;
		t_mode;
		t_frame(8'h20, 1'b1, 32'hF002A0A1, 4);
		t_frame(8'h00, 1'b0, 32'hA0A10000, 2);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(`NFR_IDX_RATE, 1'b0, 8'h00);
		t_reset;
		close_out;
	end
endmodule

/* File: sim/nfr_card_model.sv */
`timescale 1ns/1ps
module nfr_card_model (
	input  logic       hclk,
	input  logic       tx_out_valid,
	input  logic [7:0] tx_out_data,
	output logic       tx_out_ready,
	output logic       rx_sof,
	output logic       rx_in_valid,
	output logic [7:0] rx_in_data
);
	logic [7:0] got[$];
	logic [1:0] cyc = 2'h0;
	logic       slow = 1'b0;
	initial begin
		tx_out_ready = 1'b1;
		rx_sof = 1'b0;
		rx_in_valid = 1'b0;
		rx_in_data = 8'h00;
	end
	// slow card accepts one byte in four cycles
	always @(posedge hclk) begin
		cyc <= cyc + 2'h1;
		tx_out_ready <= slow ? (cyc == 2'h0) : 1'b1;
		if (tx_out_valid === 1'b1 && tx_out_ready) begin
			got.push_back(tx_out_data);
		end
	end
	// answer frame: start pulse, then two bytes
	task send(input logic [7:0] b0, input logic [7:0] b1);
		@(posedge hclk);
		rx_sof <= 1'b1;
		@(posedge hclk);
		rx_sof <= 1'b0;
		rx_in_valid <= 1'b1;
		rx_in_data <= b0;
		@(posedge hclk);
		rx_in_data <= b1;
		@(posedge hclk);
		rx_in_valid <= 1'b0;
		rx_in_data <= ~b1;
	endtask
endmodule

/* File: sim/nfr_framing_rate_sva.sv */
`timescale 1ns/1ps
module nfr_framing_rate_sva (
	input logic       hclk,
	input logic       hresetn,
	input logic       hreadyout,
	input logic       hresp,
	input logic       tx_enable,
	input logic       rx_enable,
	input logic [7:0] tx_bit_period,
	input logic [7:0] rx_bit_period,
	input logic [7:0] pulse_width,
	input logic       rx_raw_parity,
	input logic       rx_check_en,
	input logic [4:0] sof_low_hetu,
	input logic [4:0] sof_high_hetu,
	input logic [4:0] eof_low_hetu,
	input logic       tx_out_valid,
	input logic [7:0] tx_out_data,
	input logic       tx_out_ready,
	input logic       rx_in_valid,
	input logic       rx_out_valid
);
	logic live_q;
	// decoded outputs are only meaningful from the first edge after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			live_q <= 1'b0;
		end else begin
			live_q <= 1'b1;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_stall;
		tx_out_valid && !tx_out_ready;
	endsequence
	sequence s_hold;
		tx_out_valid && $stable(tx_out_data);
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready okay");
	a_tx_period: assert property (live_q |-> tx_bit_period inside {8'h80, 8'h40, 8'h20, 8'h10})
		else $error("tx period off table");
	a_rx_period: assert property (live_q |-> rx_bit_period inside {8'h80, 8'h40, 8'h20, 8'h10})
		else $error("rx period off table");
	a_pulse_off: assert property (live_q && pulse_width == 8'h00 |-> !tx_enable)
		else $error("tx on with no pulse");
	a_raw_only106: assert property (rx_raw_parity |-> rx_bit_period == 8'h80)
		else $error("raw parity off 106k");
	a_check_pair: assert property (live_q |-> rx_check_en == !rx_raw_parity)
		else $error("check enable not inverse");
	a_sof_low: assert property (live_q |-> sof_low_hetu inside {5'h14, 5'h16, 5'h15})
		else $error("sof low length");
	a_sof_high: assert property (live_q |-> sof_high_hetu inside {5'h04, 5'h06, 5'h05})
		else $error("sof high length");
	a_mid_pair: assert property (sof_high_hetu == 5'h05 |-> sof_low_hetu == 5'h15)
		else $error("mid lengths split");
	a_tx_hold: assert property (s_stall |=> s_hold)
		else $error("tx byte dropped in stall");
	a_rx_cause: assert property (rx_out_valid |-> $past(rx_in_valid) && $past(rx_enable))
		else $error("rx byte without input");
endmodule
bind nfr_framing_rate nfr_framing_rate_sva u_sva (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .tx_enable(tx_enable), .rx_enable(rx_enable),
	.tx_bit_period(tx_bit_period), .rx_bit_period(rx_bit_period), .pulse_width(pulse_width),
	.rx_raw_parity(rx_raw_parity), .rx_check_en(rx_check_en), .sof_low_hetu(sof_low_hetu),
	.sof_high_hetu(sof_high_hetu), .eof_low_hetu(eof_low_hetu), .tx_out_valid(tx_out_valid),
	.tx_out_data(tx_out_data), .tx_out_ready(tx_out_ready), .rx_in_valid(rx_in_valid),
	.rx_out_valid(rx_out_valid));
